// ### inc/frame_pkg.sv
package frame_pkg;
   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] main_control_addr  = 8'h00;
   localparam logic [7:0] frame_control_addr = 8'h04;
   localparam logic [7:0] status_addr        = 8'h08;
   localparam logic [7:0] tx_data_addr       = 8'h0C;
   localparam logic [7:0] rx_data_addr       = 8'h10;
   // ************************************************************
   // frame control fields
   // ************************************************************
   localparam int          fen_bit    = 15;
   localparam int          fdir_bit   = 14;
   localparam int          fpol_bit   = 13;
   localparam int          fdly_bit   = 1;
   localparam logic [15:0] frame_mask = 16'hE002;
   localparam logic [15:0] frame_rst  = 16'h0000;
   // ************************************************************
   // main control fields
   // ************************************************************
   localparam int          ppre_lo    = 0;
   localparam int          cke_bit    = 8;
   localparam int          ckp_bit    = 6;
   localparam logic [15:0] main_mask  = 16'h0143;
   localparam logic [15:0] main_rst   = 16'h0000;
   localparam logic [1:0]  ppre_64    = 2'h0;
   localparam logic [1:0]  ppre_16    = 2'h1;
   localparam logic [1:0]  ppre_4     = 2'h2;
   localparam logic [1:0]  ppre_1     = 2'h3;
   localparam int          word_bits  = 16;
endpackage : frame_pkg

// ### inc/shift_if.sv
`timescale 1ns/1ps
interface shift_if;
   logic        start;
   logic        busy;
   logic        done;
   logic        sck_rise;
   logic        sck_fall;
   logic [5:0]  half_div;
   modport ctrl (output start, output half_div,
                 input busy, input done, input sck_rise, input sck_fall);
   modport gen  (input start, input half_div,
                 output busy, output done, output sck_rise,
                 output sck_fall);
endinterface : shift_if

// ### design/bit_clock_gen.sv
`timescale 1ns/1ps
module bit_clock_gen #(
   parameter int bits = 17
) (
   input  wire logic pclk,
   input  wire logic presetn,
   shift_if.gen      sif
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [5:0] cnt;
      logic       phase;
      logic [5:0] edges;
      logic       busy;
      logic       done;
      logic       rise;
      logic       fall;
   } gen_t;
   gen_t s;
   gen_t next_s;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.rise = 1'b0;
      next_s.fall = 1'b0;
      if (!s.busy) begin
         if (sif.start) begin
            next_s.busy  = 1'b1;
            next_s.cnt   = sif.half_div;
            next_s.phase = 1'b0;
            next_s.edges = 6'h00;
         end
      end else if (s.cnt == 6'h00) begin
         next_s.cnt   = sif.half_div;
         next_s.phase = !s.phase;
         next_s.rise  = !s.phase;
         next_s.fall  = s.phase;
         if (s.phase) begin
            next_s.edges = s.edges + 6'h01;
            if (s.edges == 6'(bits - 1)) begin
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
            end
         end
      end else begin
         next_s.cnt = s.cnt - 6'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sif.busy     = s.busy;
   assign sif.done     = s.done;
   assign sif.sck_rise = s.rise;
   assign sif.sck_fall = s.fall;
endmodule : bit_clock_gen

// ### design/spi_framed_mode_control.sv
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
// Operation
// - framed enable bit turns framed mode on; slave select carries sync.
// - sync direction bit: 1 receive sync as slave, 0 drive it.
// - sync polarity bit: 1 active-high, 0 active-low, both directions.
// - in framed mode the clock-edge select bit is ignored.
// - primary prescale: code 01 divides by 16, code 00 by 64.
module spi_framed_mode_control (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             sck_out,
   output logic             sdo,
   input  wire logic        sdi,
   input  wire logic        slave_select_pin_in,
   output logic             slave_select_pin_out,
   output logic             slave_select_pin_oe_n
);
   // ************************************************************
   // state
   // ************************************************************
   typedef enum {idle, lead, shift, wait_sync} mode_t;
   typedef struct packed {
      logic [15:0] main_ctl;
      logic [15:0] frame_ctl;
      logic [15:0] tx;
      logic [15:0] rx;
      logic [15:0] sh;
      logic        rx_full;
      logic        pending;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic        sck;
      logic        sdo;
      logic        fs_out;
      logic        fs_oe_n;
      logic [1:0]  fs_sync;
      logic        fs_prev;
      logic [1:0]  di_sync;
      logic        first;
      logic [4:0]  nbits;
      mode_t       mode;
   } st_t;
   st_t s;
   st_t next_s;

   shift_if sif ();

   bit_clock_gen #(.bits(frame_pkg::word_bits + 1)) u_gen (
      .pclk    (pclk),
      .presetn (presetn),
      .sif     (sif)
   );

   function automatic logic [5:0] half_div(input logic [1:0] code);
      unique case (code)
         frame_pkg::ppre_64: half_div = 6'h1F;
         frame_pkg::ppre_16: half_div = 6'h07;
         frame_pkg::ppre_4:  half_div = 6'h01;
         frame_pkg::ppre_1:  half_div = 6'h00;
      endcase
   endfunction : half_div

   localparam logic [4:0] last_bit = 5'(frame_pkg::word_bits - 1);

   logic fen;
   logic fdir;
   logic fpol;
   logic fdly;
   logic ckp;
   logic acc;
   logic tx_wr;
   logic fs_active;
   assign fen  = s.frame_ctl[frame_pkg::fen_bit];
   assign fdir = s.frame_ctl[frame_pkg::fdir_bit];
   assign fpol = s.frame_ctl[frame_pkg::fpol_bit];
   assign fdly = s.frame_ctl[frame_pkg::fdly_bit];
   assign ckp  = s.main_ctl[frame_pkg::ckp_bit];
   assign acc  = psel && penable && !s.ready;
   assign tx_wr = acc && pwrite && (paddr == frame_pkg::tx_data_addr);
   assign fs_active = (s.fs_sync[1] == fpol);
   assign sif.half_div = half_div(
      s.main_ctl[frame_pkg::ppre_lo +: 2]);

   always_comb begin
      next_s = s;
      next_s.ready = acc;
      next_s.err   = 1'b0;
      next_s.fs_sync = {s.fs_sync[0], slave_select_pin_in};
      next_s.di_sync = {s.di_sync[0], sdi};
      next_s.fs_prev = s.fs_sync[1];
      sif.start = 1'b0;
      // ************************************************************
      // apb slave, one wait state
      // ************************************************************
      if (acc) begin
         next_s.rdata = 32'h0000_0000;
         unique case (paddr)
            frame_pkg::main_control_addr: begin
               if (pwrite) begin
                  next_s.main_ctl = pwdata[15:0] & frame_pkg::main_mask;
               end
               next_s.rdata[15:0] = s.main_ctl;
            end
            frame_pkg::frame_control_addr: begin
               if (pwrite) begin
                  next_s.frame_ctl = pwdata[15:0] & frame_pkg::frame_mask;
               end
               next_s.rdata[15:0] = s.frame_ctl;
            end
            frame_pkg::status_addr: begin
               next_s.rdata[2:0] = {s.mode != idle, s.pending, s.rx_full};
            end
            frame_pkg::tx_data_addr: begin
               if (pwrite) begin
                  next_s.tx      = pwdata[15:0];
                  next_s.pending = 1'b1;
               end
               next_s.rdata[15:0] = s.tx;
            end
            frame_pkg::rx_data_addr: begin
               next_s.rdata[15:0] = s.rx;
               if (!pwrite) begin
                  next_s.rx_full = 1'b0;
               end
            end
            default: next_s.err = 1'b1;
         endcase
      end
      next_s.fs_oe_n = !(fen && !fdir);
      next_s.sck     = ckp;
      unique case (s.mode)
         idle: begin
            next_s.fs_out = !fpol;
            next_s.first  = 1'b1;
            // framed start: master on data, slave on sync
            // a tx write in the start cycle keeps pending: set wins
            if (fen && s.pending && !fdir && !sif.busy) begin
               sif.start      = 1'b1;
               next_s.sh      = s.tx;
               next_s.nbits   = 5'h00;
               next_s.pending = tx_wr;
               next_s.mode    = fdly ? lead : shift;
            end else if (fen && fdir) begin
               next_s.mode    = wait_sync;
            end
         end
         wait_sync: begin
            if (!fen || !fdir) begin
               next_s.mode = idle;
            end else if (fs_active && (s.fs_prev != fpol) && !sif.busy) begin
               sif.start      = 1'b1;
               next_s.sh      = s.tx;
               next_s.nbits   = 5'h00;
               next_s.pending = tx_wr;
               next_s.mode    = fdly ? lead : shift;
            end
         end
         lead: begin
            next_s.fs_out = fpol;
            if (sif.sck_fall) begin
               next_s.fs_out = !fpol;
               next_s.mode   = shift;
            end
         end
         shift: begin
            next_s.sck = s.sck ^ sif.sck_rise ^ sif.sck_fall;
            // framed: data changes on idle-to-active edge, cke unused
            if (sif.sck_rise) begin
               next_s.sdo = s.sh[15];
            end
            if (sif.sck_fall) begin
               next_s.sh    = {s.sh[14:0], s.di_sync[1]};
               next_s.first = 1'b0;
               next_s.nbits = s.nbits + 5'h01;
            end
            // without lead, sync with first bit, dropped as it ends
            next_s.fs_out = (next_s.first && !fdly) ? fpol : !fpol;
            // own bit count: without lead the generator runs one period on
            if (sif.sck_fall && (s.nbits == last_bit)) begin
               next_s.rx      = next_s.sh;
               next_s.rx_full = 1'b1;
               next_s.mode    = idle;
            end
         end
      endcase
      // non-framed operation lives in the main shift engine
      if (!fen) begin
         next_s.mode   = idle;
         next_s.fs_out = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s           <= '0;
         s.main_ctl  <= frame_pkg::main_rst;
         s.frame_ctl <= frame_pkg::frame_rst;
         s.fs_out    <= 1'b1;
         s.fs_oe_n   <= 1'b1;
         s.mode      <= idle;
      end else begin
         s <= next_s;
      end
   end

   assign prdata                = s.rdata;
   assign pready                = s.ready;
   assign pslverr               = s.err;
   assign sck_out               = s.sck;
   assign sdo                   = s.sdo;
   assign slave_select_pin_out  = s.fs_out;
   assign slave_select_pin_oe_n = s.fs_oe_n;
endmodule : spi_framed_mode_control

// ### tb/spi_frame_props_properties.sv
`timescale 1ns/1ps
module spi_frame_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sck_out,
   input wire logic        sdo,
   input wire logic        sdi,
   input wire logic        slave_select_pin_in,
   input wire logic        slave_select_pin_out,
   input wire logic        slave_select_pin_oe_n
);
   // ********
   // shadow of the settings, taken from finished writes
   // ********
   typedef struct packed {
      logic       fen, dir, pol, sq;
      logic [1:0] pre;
      logic [7:0] act, gap;
   } shadow_t;
   shadow_t m, next_m;
   int      per;
   logic    drv;
   assign per = 64 >> (2 * m.pre);
   assign drv = !slave_select_pin_oe_n;
   always_comb begin
      next_m = m;
      next_m.sq = sck_out;
      if (psel && penable && pready && pwrite) begin
         if (paddr == frame_pkg::frame_control_addr)
            {next_m.fen, next_m.dir, next_m.pol} = pwdata[15:13];
         if (paddr == frame_pkg::main_control_addr)
            next_m.pre = pwdata[1:0];
      end
      next_m.act = (drv && slave_select_pin_out == m.pol) ?
                   m.act + 8'h01 : 8'h00;
      // saturates so a long idle never wraps into a short gap
      if (sck_out != m.sq)
         next_m.gap = 8'h01;
      else if (m.gap != 8'hFF)
         next_m.gap = m.gap + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         m <= '0;
      else
         m <= next_m;
   end
   // ********
   // checks
   // ********
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_wait;
      psel && penable && !pready;
   endsequence
   sequence hold_master;
      (m.fen && !m.dir) [*3];
   endsequence
   a_ready_next: assert property (acc_wait |=> pready)
      else $error("no ready after access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_paired: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_master_drives: assert property (hold_master |-> drv)
      else $error("sync not driven in framed master");
   a_off_released: assert property
      ((!m.fen) [*3] |-> slave_select_pin_oe_n)
      else $error("sync driven with framing off");
   a_slave_listens: assert property
      (m.dir [*3] |-> slave_select_pin_oe_n)
      else $error("sync driven in slave role");
   a_sync_width: assert property (m.act <= per)
      else $error("sync active longer than a bit");
   a_clock_rate: assert property
      (sck_out != m.sq |-> m.gap >= per / 2)
      else $error("serial clock faster than prescale");
endmodule : spi_frame_props
bind spi_framed_mode_control spi_frame_props props (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .sck_out, .sdo, .sdi, .slave_select_pin_in,
   .slave_select_pin_out, .slave_select_pin_oe_n);

// ### tb/serial_far_end.sv
`timescale 1ns/1ps
module serial_far_end (
   input  wire logic   pclk,
   input  wire logic   sck,
   input  wire logic   sdo,
   input  wire logic   fs_go,
   input  wire logic   fs_pol,
   output logic        sdi,
   output logic        fs_line,
   output logic [31:0] heard
);
   logic sck_q;
   initial begin
      sck_q = 1'b0;
      sdi = 1'b0;
      heard = 32'h0;
   end
   assign fs_line = fs_go ? fs_pol : !fs_pol;
   // outside clock edges the data line churns, never a stale bit
   always @(posedge pclk) begin
      sck_q <= sck;
      if (sck != sck_q) begin
         heard <= {heard[30:0], sdo};
         sdi <= !sdi ^ sdo;
      end else
         sdi <= !sdi;
   end
endmodule : serial_far_end

// ### tb/spi_framed_mode_control_tb.sv
`timescale 1ns/1ps
module spi_framed_mode_control_tb;
   localparam logic [7:0] mctl = frame_pkg::main_control_addr;
   localparam logic [7:0] fctl = frame_pkg::frame_control_addr;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        sck_out, sdo, sdi, ss_out, ss_oe_n, pin, fs_line;
   logic        fs_go, fs_pol, err, sq, act;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, v, heard, h0;
   logic [15:0] tx;
   int          miscompares, n_checks, s, f, e, wid, c;
   assign pin = ss_oe_n ? fs_line : ss_out;
   spi_framed_mode_control dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sck_out,
      .sdo, .sdi, .slave_select_pin_in(pin),
      .slave_select_pin_out(ss_out), .slave_select_pin_oe_n(ss_oe_n));
   serial_far_end far (.pclk, .sck(sck_out), .sdo, .fs_go, .fs_pol,
      .sdi, .fs_line, .heard);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // ********
   // tasks
   // ********
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask : check
   // far end logs every sck change, so each bit is heard twice
   function automatic logic [31:0] doubled(input logic [15:0] d);
      for (int i = 0; i < 16; i++) begin
         doubled[2 * i +: 2] = {2{d[i]}};
      end
   endfunction : doubled
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1) begin
         check(1'b0, 1'b1, "bus timeout");
         report_and_stop();
      end
   endtask : apb
   task automatic run_frame(input logic [15:0] d, input int p,
                            input logic dly, input logic pol);
      apb(1'b1, frame_pkg::tx_data_addr, {16'h0, d});
      {s, f, e, wid, c} = {-32'sd1, -32'sd1, 96'h0};
      sq = sck_out;
      for (int i = 0; i < 20 * p + 40; i++) begin
         @(posedge pclk);
         act = !ss_oe_n && ss_out === pol;
         wid += act;
         if (act && s < 0) s = i;
         if (sck_out !== sq) c++;
         if (sck_out !== sq && c == 1) f = i;
         if (sck_out !== sq && c == 3) e = i;
         sq = sck_out;
      end
      check(wid, p, "sync width");
      check(e - f, p, "bit clock period");
      check(f - s >= p, dly, "sync lead");
      apb(1'b0, frame_pkg::status_addr, 32'h0);
      check(rd[2:1], 2'h0, "frame not finished");
   endtask : run_frame
   // ********
   // sequence
   // ********
   initial begin
      void'($urandom(32'h6DB1));
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {presetn, fs_go, fs_pol} = '0;
      miscompares = 0;
      n_checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, mctl, 32'h0);
      check(rd, {16'h0, frame_pkg::main_rst}, "main reset");
      apb(1'b0, fctl, 32'h0);
      check(rd, {16'h0, frame_pkg::frame_rst}, "frame reset");
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      check(err, 1'b1, "unmapped write");
      apb(1'b0, 8'h20, 32'h0);
      check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
      for (int i = 0; i < 8; i++) begin
         // back to off, so a released sync line never looks like an edge
         apb(1'b1, fctl, 32'h0);
         v = $urandom & 32'hFFFF_FFFE;
         apb(1'b1, fctl, v);
         apb(1'b0, fctl, 32'h0);
         check(rd, v & 32'(frame_pkg::frame_mask), "readback");
         check(ss_oe_n, !(v[15] && !v[14]), "sync drive");
      end
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, mctl, {30'h0, frame_pkg::ppre_16});
         apb(1'b1, fctl, {16'h0, 2'b10, k[0], 11'h0, k[1], 1'b0});
         repeat (2) @(posedge pclk);
         check(ss_out, !k[0], "sync idle level");
         run_frame(16'($urandom), 16, k[1], k[0]);
      end
      $display("test framed master done");
      tx = 16'($urandom);
      run_frame(tx, 16, 1'b1, 1'b1);
      h0 = heard;
      check(h0, doubled(tx), "sent data");
      apb(1'b1, mctl, {23'h0, 1'b1, 6'h0, frame_pkg::ppre_16});
      run_frame(tx, 16, 1'b1, 1'b1);
      check(heard, h0, "edge select used");
      apb(1'b1, mctl, {30'h0, frame_pkg::ppre_64});
      run_frame(16'($urandom), 64, 1'b1, 1'b1);
      $display("test edge select and prescale done");
      apb(1'b0, frame_pkg::rx_data_addr, 32'h0);
      apb(1'b1, fctl, 32'h0000_E000);
      fs_pol <= 1'b1;
      // long enough for the slave frame to end before framing is cut
      for (int i = 0; i < 1200; i++) begin
         @(posedge pclk);
         fs_go <= (i > 4 && i < 21);
         check(ss_oe_n, 1'b1, "slave drove sync");
      end
      apb(1'b0, frame_pkg::status_addr, 32'h0);
      check(rd[0], 1'b1, "slave frame not received");
      apb(1'b1, fctl, 32'h0000_2000);
      apb(1'b1, frame_pkg::tx_data_addr, 32'h0000_A5C3);
      for (int i = 0; i < 60; i++) begin
         @(posedge pclk);
         check(ss_oe_n, 1'b1, "sync driven while off");
      end
      $display("test slave and off done");
      report_and_stop();
   end
endmodule : spi_framed_mode_control_tb
